// ==== common/eeprom_addr_pkg.sv ====
// Shared constants and types for the data EEPROM address capture block
package eeprom_addr_pkg;

    // ---------------------------------------------------------------
    // Register map (byte addresses on the AXI4-Lite bus)
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR        = 8'h00;
    localparam logic [7:0] STATUS_ADDR      = 8'h04;
    localparam logic [7:0] RDDATA_ADDR      = 8'h08;
    localparam logic [7:0] TABLE_PAGE_IDX   = 8'h32;
    localparam logic [7:0] TABLE_PAGE_ADDR  = TABLE_PAGE_IDX << 2;
    localparam logic [7:0] TABLE_PAGE_RESET = 8'h00;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int OP_LSB    = 0;
    localparam int START_BIT = 8;
    localparam int BUSY_BIT  = 0;
    localparam int RDWB_BIT  = 1;

    // Row alignment masks on the lower address word
    localparam logic [15:0] ROW4_MASK = 16'hfff8;
    localparam logic [15:0] ROW8_MASK = 16'hfff0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_ERASE1 = 3'h0,
        OP_ERASE4 = 3'h1,
        OP_ERASE8 = 3'h2,
        OP_BULK   = 3'h3,
        OP_WRITE  = 3'h4,
        OP_READ   = 3'h5
    } nvm_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_BUSY = 2'h2
    } state_t;

endpackage

// ==== core/axil_reg_port.sv ====
// AXI4-Lite slave front end that turns bus transfers into register strobes
module axil_reg_port #(
    parameter int AW = 8
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    output logic               regWrEn,
    output logic [AW-1:0]      regWrAddr,
    output logic [31:0]        regWrData,
    output logic [3:0]         regWrStrb,
    input  wire logic          regWrOk,
    output logic               regRdEn,
    output logic [AW-1:0]      regRdAddr,
    input  wire logic [31:0]   regRdData,
    input  wire logic          regRdOk
);

    typedef struct packed {
        logic          awHeld;
        logic [AW-1:0] awAddr;
        logic          wHeld;
        logic [31:0]   wData;
        logic [3:0]    wStrb;
        logic          bValid;
        logic [1:0]    bResp;
        logic          rValid;
        logic [31:0]   rData;
        logic [1:0]    rResp;
    } axs_t;

    axs_t st;
    axs_t next_st;

    // Address and data are parked separately so they may arrive in either order
    always_comb begin
        next_st   = st;
        awready   = ce & ~st.awHeld & ~st.bValid;
        wready    = ce & ~st.wHeld & ~st.bValid;
        arready   = ce & ~st.rValid;
        regWrEn   = ce & st.awHeld & st.wHeld & ~st.bValid;
        regWrAddr = st.awAddr;
        regWrData = st.wData;
        regWrStrb = st.wStrb;
        regRdEn   = arvalid & arready;
        regRdAddr = araddr;
        if (awvalid && awready) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            next_st.wHeld = 1'b1;
            next_st.wData = wdata;
            next_st.wStrb = wstrb;
        end
        if (regWrEn) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld  = 1'b0;
            next_st.bValid = 1'b1;
            next_st.bResp  = regWrOk ? eeprom_addr_pkg::RESP_OKAY
                                     : eeprom_addr_pkg::RESP_SLVERR;
        end
        if (st.bValid && bready) begin
            next_st.bValid = 1'b0;
        end
        if (regRdEn) begin
            next_st.rValid = 1'b1;
            next_st.rData  = regRdOk ? regRdData : 32'h0000_0000;
            next_st.rResp  = regRdOk ? eeprom_addr_pkg::RESP_OKAY
                                     : eeprom_addr_pkg::RESP_SLVERR;
        end
        if (st.rValid && rready) begin
            next_st.rValid = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign bvalid = st.bValid;
    assign bresp  = st.bResp;
    assign rvalid = st.rValid;
    assign rdata  = st.rData;
    assign rresp  = st.rResp;

endmodule

// ==== core/eeprom_address_capture.sv ====
// Data EEPROM effective address capture with table page register and op launch
//
// How it works
// [R1] A 24-bit address is kept: 8-bit upper byte and 16-bit lower word.
// [R2] Capture registers are off the register map and load on every low-word table write while ce is high.
// [R3] The captured address selects the row that the next erase other than bulk acts on.
// [R4] Lower word bit zero is always cleared; only even addresses exist.
// [R5] Upper byte top bit is always cleared; all addresses are user space.
// [R6] Table page register: index 0x32, resets to zero, only low 8 bits live.
// [R7] Only the low data word is used; high-word table writes are ignored.
// [R8] Six launchable ops: erase one, four, eight words, bulk, write, read.
// [R9] Software must not read while an erase or write is still running.
// [R10] Table write takes upper byte from page register, lower word from EA.
module eeprom_address_capture #(
    parameter int AW = 8
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    input  wire logic          tblWrEn,
    input  wire logic          tblWrHigh,
    input  wire logic [15:0]   tblWrEa,
    input  wire logic [15:0]   tblWrData,
    output logic [7:0]         nvmAddrUpper,
    output logic [15:0]        nvmAddrLower,
    output logic               nvmCmdValid,
    output logic [2:0]         nvmCmdOp,
    output logic [23:0]        nvmRowAddr,
    output logic [15:0]        nvmWrData,
    input  wire logic          nvmDone,
    input  wire logic [15:0]   nvmRdData
);

    typedef struct packed {
        eeprom_addr_pkg::state_t fsm;
        logic [7:0]              tblPage;
        logic [7:0]              addrUpper; // R1
        logic [15:0]             addrLower; // R1
        logic [15:0]             wrData;
        logic [2:0]              op;
        logic [2:0]              cmdOp;
        logic                    cmdValid;
        logic [23:0]             rowAddr;
        logic                    rdWhileBusy;
        logic [15:0]             rdData;
    } core_t;

    localparam core_t RST = '{
        fsm:       eeprom_addr_pkg::ST_IDLE,
        tblPage:   eeprom_addr_pkg::TABLE_PAGE_RESET,
        default:   '0
    };

    core_t st;
    core_t next_st;

    logic            regWrEn;
    logic [AW-1:0]   regWrAddr;
    logic [31:0]     regWrData;
    logic [3:0]      regWrStrb;
    logic            regWrOk;
    logic            regRdEn;
    logic [AW-1:0]   regRdAddr;
    logic [31:0]     regRdData;
    logic            regRdOk;
    logic            startReq;
    logic [2:0]      opSel;
    logic            busy;

    axil_reg_port #(.AW(AW)) bus (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .ce        (ce),
        .awaddr    (awaddr),
        .awvalid   (awvalid),
        .awready   (awready),
        .wdata     (wdata),
        .wstrb     (wstrb),
        .wvalid    (wvalid),
        .wready    (wready),
        .bresp     (bresp),
        .bvalid    (bvalid),
        .bready    (bready),
        .araddr    (araddr),
        .arvalid   (arvalid),
        .arready   (arready),
        .rdata     (rdata),
        .rresp     (rresp),
        .rvalid    (rvalid),
        .rready    (rready),
        .regWrEn   (regWrEn),
        .regWrAddr (regWrAddr),
        .regWrData (regWrData),
        .regWrStrb (regWrStrb),
        .regWrOk   (regWrOk),
        .regRdEn   (regRdEn),
        .regRdAddr (regRdAddr),
        .regRdData (regRdData),
        .regRdOk   (regRdOk)
    );

    assign busy = (st.fsm == eeprom_addr_pkg::ST_BUSY);

    // ---------------------------------------------------------------
    // Register read and write decode
    // ---------------------------------------------------------------
    // The capture registers have no address on purpose
    always_comb begin
        regRdData = 32'h0000_0000;
        regRdOk   = 1'b1;
        case (8'(regRdAddr))
            eeprom_addr_pkg::CTRL_ADDR:       regRdData[2:0] = st.op;
            eeprom_addr_pkg::STATUS_ADDR: begin
                regRdData[eeprom_addr_pkg::BUSY_BIT] = busy;
                regRdData[eeprom_addr_pkg::RDWB_BIT] = st.rdWhileBusy;
            end
            eeprom_addr_pkg::RDDATA_ADDR:     regRdData[15:0] = st.rdData;
            eeprom_addr_pkg::TABLE_PAGE_ADDR: regRdData[7:0] = st.tblPage; // R6
            default:                          regRdOk = 1'b0;
        endcase
    end

    always_comb begin
        case (8'(regWrAddr))
            eeprom_addr_pkg::CTRL_ADDR,
            eeprom_addr_pkg::STATUS_ADDR,
            eeprom_addr_pkg::RDDATA_ADDR,
            eeprom_addr_pkg::TABLE_PAGE_ADDR: regWrOk = 1'b1;
            default:                          regWrOk = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // Core state
    // ---------------------------------------------------------------
    always_comb begin
        next_st          = st;
        next_st.cmdValid = 1'b0;
        startReq = regWrEn && (8'(regWrAddr) == eeprom_addr_pkg::CTRL_ADDR)
                   && regWrStrb[1] && regWrData[eeprom_addr_pkg::START_BIT];
        opSel    = regWrStrb[0] ? regWrData[eeprom_addr_pkg::OP_LSB +: 3] : st.op;

        if (regWrEn && regWrStrb[0]) begin
            case (8'(regWrAddr))
                eeprom_addr_pkg::CTRL_ADDR:
                    next_st.op = regWrData[eeprom_addr_pkg::OP_LSB +: 3];
                eeprom_addr_pkg::TABLE_PAGE_ADDR:
                    next_st.tblPage = regWrData[7:0]; // R6
                eeprom_addr_pkg::STATUS_ADDR:
                    if (regWrData[eeprom_addr_pkg::RDWB_BIT]) begin
                        next_st.rdWhileBusy = 1'b0;
                    end
                default: ;
            endcase
        end

        // High-word writes carry nothing for a 16-bit array
        if (tblWrEn && !tblWrHigh) begin // R7
            next_st.addrUpper = {1'b0, st.tblPage[6:0]}; // R10 R5
            next_st.addrLower = {tblWrEa[15:1], 1'b0}; // R10 R4 R2
            next_st.wrData    = tblWrData;
        end

        case (st.fsm)
            eeprom_addr_pkg::ST_IDLE: begin
                if (startReq && opSel <= 3'(eeprom_addr_pkg::OP_READ)) begin // R8
                    next_st.fsm      = eeprom_addr_pkg::ST_BUSY;
                    next_st.cmdValid = 1'b1;
                    next_st.cmdOp    = opSel;
                    case (opSel)
                        3'(eeprom_addr_pkg::OP_ERASE4):
                            next_st.rowAddr = {st.addrUpper,
                                               st.addrLower & eeprom_addr_pkg::ROW4_MASK}; // R3
                        3'(eeprom_addr_pkg::OP_ERASE8):
                            next_st.rowAddr = {st.addrUpper,
                                               st.addrLower & eeprom_addr_pkg::ROW8_MASK}; // R3
                        3'(eeprom_addr_pkg::OP_BULK):
                            next_st.rowAddr = 24'h00_0000;
                        default:
                            next_st.rowAddr = {st.addrUpper, st.addrLower}; // R3
                    endcase
                end
            end
            eeprom_addr_pkg::ST_BUSY: begin
                // A read launched mid-operation would return garbage
                if (startReq && opSel == 3'(eeprom_addr_pkg::OP_READ)) begin // R9
                    next_st.rdWhileBusy = 1'b1;
                end
                if (nvmDone) begin
                    next_st.fsm = eeprom_addr_pkg::ST_IDLE;
                    if (st.cmdOp == 3'(eeprom_addr_pkg::OP_READ)) begin
                        next_st.rdData = nvmRdData;
                    end
                end
            end
            default: next_st.fsm = eeprom_addr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign nvmAddrUpper = st.addrUpper;
    assign nvmAddrLower = st.addrLower;
    assign nvmCmdValid  = st.cmdValid;
    assign nvmCmdOp     = st.cmdOp;
    assign nvmRowAddr   = st.rowAddr;
    assign nvmWrData    = st.wrData;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_lsb_even: assert property (@(posedge mclk) disable iff (!rst_n) // R4
        nvmAddrLower[0] == 1'b0 && nvmRowAddr[0] == 1'b0)
        else $error("lower address bit zero is set");

    a_msb_clear: assert property (@(posedge mclk) disable iff (!rst_n) // R5
        nvmAddrUpper[7] == 1'b0 && nvmRowAddr[23] == 1'b0)
        else $error("upper address top bit is set");

    a_capture_word: assert property (@(posedge mclk) disable iff (!rst_n) // R10
        ce && tblWrEn && !tblWrHigh |=>
            nvmAddrLower == {$past(tblWrEa[15:1]), 1'b0}
            && nvmAddrUpper == {1'b0, $past(st.tblPage[6:0])})
        else $error("table write address not captured");

    a_high_ignored: assert property (@(posedge mclk) disable iff (!rst_n) // R7
        ce && tblWrEn && tblWrHigh |=> $stable(nvmAddrLower) && $stable(nvmAddrUpper))
        else $error("high word write changed capture");

    a_page_reset: assert property (@(posedge mclk) disable iff (!rst_n) // R6
        $rose(rst_n) |-> st.tblPage == eeprom_addr_pkg::TABLE_PAGE_RESET)
        else $error("table page not zero after reset");

    a_row_erase8: assert property (@(posedge mclk) disable iff (!rst_n) // R3
        nvmCmdValid && nvmCmdOp == 3'(eeprom_addr_pkg::OP_ERASE8) |->
            nvmRowAddr == {$past(st.addrUpper),
                           $past(st.addrLower) & eeprom_addr_pkg::ROW8_MASK})
        else $error("erase row not from captured address");

    a_launch_once: assert property (@(posedge mclk) disable iff (!rst_n) // R8
        nvmCmdValid |-> busy ##1 !nvmCmdValid)
        else $error("command pulse malformed");

    a_busy_flag: assert property (@(posedge mclk) disable iff (!rst_n) // R9
        ce && busy && !nvmDone && startReq && opSel == 3'(eeprom_addr_pkg::OP_READ)
            |=> st.rdWhileBusy && busy)
        else $error("read during operation not flagged");

endmodule

// ==== verif/nvm_array_model.sv ====
// Behavioural data array that answers launched operations after a set latency
module nvm_array_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        nvmCmdValid,
    input  wire logic [23:0] nvmRowAddr,
    input  wire logic [7:0]  latency,
    output logic             nvmDone,
    output logic [15:0]      nvmRdData
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0]  cnt;
    logic        busy;
    logic [15:0] rowWord;

    initial begin
        nvmDone   = 1'b0;
        nvmRdData = 16'h0000;
        busy      = 1'b0;
        cnt       = 8'h00;
        rowWord   = 16'h0000;
    end

    always @(posedge mclk) begin
        nvmDone   <= 1'b0;
        // Data means nothing outside done; toggling exposes early sampling
        nvmRdData <= ~nvmRdData;
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (nvmCmdValid === 1'b1) begin
            busy    <= 1'b1;
            cnt     <= latency;
            rowWord <= nvmRowAddr[15:0];
        end else if (busy) begin
            if (cnt == 8'h00) begin
                nvmDone   <= 1'b1;
                nvmRdData <= rowWord ^ 16'h5a5a;
                busy      <= 1'b0;
            end else begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule

// ==== verif/tb_eeprom_address_capture.sv ====
// Self-checking bench for the data EEPROM address capture block
module tb_eeprom_address_capture;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk, rst_n, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, tblWrEn, tblWrHigh, nvmCmdValid, nvmDone;
    logic [7:0]  awaddr, araddr, nvmAddrUpper, latency;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] tblWrEa, tblWrData, nvmAddrLower, nvmWrData, nvmRdData;
    logic [2:0]  nvmCmdOp, seenOp;
    logic [23:0] nvmRowAddr, seenRow;
    int          errorCnt = 0, checksDone = 0, cmdSeen = 0;
    int          seed, page, expU, expL, expD, n, i, op;

    eeprom_address_capture u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .tblWrEn(tblWrEn), .tblWrHigh(tblWrHigh), .tblWrEa(tblWrEa),
        .tblWrData(tblWrData), .nvmAddrUpper(nvmAddrUpper), .nvmAddrLower(nvmAddrLower),
        .nvmCmdValid(nvmCmdValid), .nvmCmdOp(nvmCmdOp), .nvmRowAddr(nvmRowAddr),
        .nvmWrData(nvmWrData), .nvmDone(nvmDone), .nvmRdData(nvmRdData));

    nvm_array_model u_array (.mclk(mclk), .rst_n(rst_n), .nvmCmdValid(nvmCmdValid),
        .nvmRowAddr(nvmRowAddr), .latency(latency), .nvmDone(nvmDone), .nvmRdData(nvmRdData));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (nvmCmdValid === 1'b1) begin
            seenOp  <= nvmCmdOp;
            seenRow <= nvmRowAddr;
            cmdSeen <= cmdSeen + 1;
        end
    end

    // ---------------------------------------------------------------
    // Compare tasks and bus master
    // ---------------------------------------------------------------
    task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED bus at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkPort(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED port at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Handshakes are sampled mid-cycle, where nothing moves before the next edge
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                            input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] resp;
        int k;
        awaddr  <= a;
        wdata   <= v;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        k = 0;
        do begin
            @(negedge mclk);
            aw = awready & awvalid;
            w = wready & wvalid;
            b = bvalid;
            resp = bresp;
            @(posedge mclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            k++;
        end while (b !== 1'b1 && k < 60);
        if (b !== 1'b1) errorCnt++;
        bready <= 1'b0;
        chkReg(resp, er);
        // Idle edge: next call must not drive bready twice, and monitor NBAs settle
        @(posedge mclk);
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        logic ar, rv;
        int k;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        k = 0;
        do begin
            @(negedge mclk);
            ar = arready & arvalid;
            rv = rvalid;
            v = rdata;
            e = rresp;
            @(posedge mclk);
            if (ar) arvalid <= 1'b0;
            k++;
        end while (rv !== 1'b1 && k < 60);
        if (rv !== 1'b1) errorCnt++;
        rready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic regCheck(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
        axiRead(a, d, r);
        chkReg(d, ev);
        chkReg(r, er);
    endtask

    task automatic tblWr(input logic [15:0] ea, input logic [15:0] dv, input logic hi);
        tblWrEa   <= ea;
        tblWrData <= dv;
        tblWrHigh <= hi;
        tblWrEn   <= 1'b1;
        @(posedge mclk);
        tblWrEn <= 1'b0;
        if (!hi) begin
            expU = page & 'h7f;
            expL = ea & 'hfffe;
            expD = dv;
        end
        @(negedge mclk);
        chkPort(nvmAddrUpper, expU);
        chkPort(nvmAddrLower, expL);
        chkPort(nvmWrData, expD);
        @(posedge mclk);
    endtask

    function automatic logic [31:0] expRow(input int o);
        case (o)
            1: return (expU << 16) | (expL & 'hfff8);
            2: return (expU << 16) | (expL & 'hfff0);
            3: return 32'h0;
            default: return (expU << 16) | expL;
        endcase
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        errorCnt++;
        conclude();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        seed = 32'h82ba201f;
        {rst_n, awvalid, wvalid, bready, arvalid, rready, tblWrEn, tblWrHigh} = 8'h00;
        ce = 1'b1;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {tblWrEa, tblWrData, expU, expL, expD, page} = 160'h0;
        latency = 8'h00;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        regCheck(eeprom_addr_pkg::TABLE_PAGE_ADDR, 32'h0, eeprom_addr_pkg::RESP_OKAY);
        regCheck(eeprom_addr_pkg::STATUS_ADDR, 32'h0, eeprom_addr_pkg::RESP_OKAY);
        axiWrite(eeprom_addr_pkg::TABLE_PAGE_ADDR, 32'hffffffff, 4'hf, 2'h0);
        regCheck(eeprom_addr_pkg::TABLE_PAGE_ADDR, 32'hff, 2'h0);
        axiWrite(8'h40, 32'h1, 4'hf, eeprom_addr_pkg::RESP_SLVERR);
        regCheck(8'h40, 32'h0, eeprom_addr_pkg::RESP_SLVERR);
        axiWrite(eeprom_addr_pkg::RDDATA_ADDR, 32'hffff, 4'hf, 2'h0);
        regCheck(eeprom_addr_pkg::RDDATA_ADDR, 32'h0, 2'h0);
        for (i = 0; i < 12; i++) begin
            page = $random(seed) & 'hff;
            axiWrite(eeprom_addr_pkg::TABLE_PAGE_ADDR, page, 4'h1, 2'h0);
            tblWr(16'($random(seed)), 16'($random(seed)), (i % 4) == 3);
        end
        // A table write while the clock enable is low must leave the capture alone
        ce        <= 1'b0;
        tblWrEa   <= 16'h1234;
        tblWrHigh <= 1'b0;
        tblWrEn   <= 1'b1;
        @(posedge mclk);
        tblWrEn <= 1'b0;
        ce      <= 1'b1;
        @(negedge mclk);
        chkPort(nvmAddrLower, expL);
        @(posedge mclk);
        for (op = 0; op < 6; op++) begin
            page = $random(seed) & 'hff;
            axiWrite(eeprom_addr_pkg::TABLE_PAGE_ADDR, page, 4'hf, 2'h0);
            tblWr(16'($random(seed)), 16'($random(seed)), 1'b0);
            latency <= (op == 5) ? 8'd20 : 8'(op);
            n = cmdSeen;
            axiWrite(eeprom_addr_pkg::CTRL_ADDR, 32'h100 | op, 4'h3, 2'h0);
            chkPort(seenOp, op);
            chkPort(seenRow, expRow(op));
            if (op == 5) begin
                // A second start while busy must launch nothing and flag the read
                axiWrite(eeprom_addr_pkg::CTRL_ADDR, 32'h100, 4'h2, 2'h0);
                regCheck(eeprom_addr_pkg::STATUS_ADDR, 32'h3, 2'h0);
            end
            chkPort(cmdSeen - n, 1);
            i = 0;
            do begin
                axiRead(eeprom_addr_pkg::STATUS_ADDR, d, r);
                i++;
            end while (d[0] !== 1'b0 && i < 40);
            chkReg(d & 32'h1, 32'h0);
            if (op == 5) begin
                regCheck(eeprom_addr_pkg::RDDATA_ADDR, expL ^ 'h5a5a, 2'h0);
                axiWrite(eeprom_addr_pkg::STATUS_ADDR, 32'h2, 4'h1, 2'h0);
                regCheck(eeprom_addr_pkg::STATUS_ADDR, 32'h0, 2'h0);
            end
        end
        // Op code 6 is outside the command set: stored, but nothing launches
        n = cmdSeen;
        axiWrite(eeprom_addr_pkg::CTRL_ADDR, 32'h106, 4'h3, 2'h0);
        regCheck(eeprom_addr_pkg::CTRL_ADDR, 32'h6, 2'h0);
        chkPort(cmdSeen - n, 0);
        conclude();
    end
endmodule
